// *** hdl/timer_counter_regs.vh ***
// register map, field positions and timing constants of the timer block
// assumes inclusion by both design files; definitions only
`ifndef TIMER_COUNTER_REGS_VH
`define TIMER_COUNTER_REGS_VH

// ========================================================
// register byte offsets (address bits 4..0)
`define OFS_CTRL 5'h00
`define OFS_MODE 5'h04
`define OFS_C0_LOW 5'h08
`define OFS_C0_HIGH 5'h0C
`define OFS_C1_LOW 5'h10
`define OFS_C1_HIGH 5'h14
`define OFS_IRQ_STAT 5'h18
`define OFS_IRQ_MASK 5'h1C

// ========================================================
// counter_control_register bit positions
`define CTL_TYPE0 0
`define CTL_EXTF0 1
`define CTL_TYPE1 2
`define CTL_EXTF1 3
`define CTL_RUN0 4
`define CTL_OVF0 5
`define CTL_RUN1 6
`define CTL_OVF1 7

// ========================================================
// counter_mode_register nibble layout
`define MD_C1_LSB 4
`define MD_SEL_LO 0
`define MD_SEL_HI 1
`define MD_SRC 2
`define MD_GATE 3

// mode codes handled here
`define MODE_13BIT 2'h0
`define MODE_16BIT 2'h1

// ========================================================
// interrupt status / mask bit positions
`define IST_OVF0 0
`define IST_OVF1 1
`define IST_EXT0 2
`define IST_EXT1 3

// ========================================================
// counting and timing constants, bus response codes
`define PER_CLOCKS 6
`define DIV_LAST 3'h5
`define PRESCALE_TOP 5'h1F
`define BYTE_MAX 8'hFF
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** hdl/counter_channel.v ***
// one counter channel: count bytes, source choice, gating, overflow
// assumes synchronised pins and a one-cycle peripheral tick on mclk_i
`timescale 1ns/100ps
`include "timer_counter_regs.vh"

module counter_channel (
   input wire mclk_i,
   input wire rst_b_i,
   input wire per_tick_i,
   input wire run_i,
   input wire gate_en_i,
   input wire src_sel_i,
   input wire [1:0] mode_i,
   input wire gate_pin_i,
   input wire count_pin_i,
   input wire wr_low_i,
   input wire wr_high_i,
   input wire [7:0] wdata_i,
   output reg [7:0] low_o,
   output reg [7:0] high_o,
   output reg ovf_o
);

   // ========================================================
   // sampling and enable
   reg sample_reg; // count pin as seen at the last tick
   reg [7:0] low_next;
   reg [7:0] high_next;
   reg ovf_next;
   wire gate_ok; // pin lets the count proceed
   wire enable; // run and gate conditions met
   wire fall_seen; // high at last tick, low now
   wire step; // one increment this cycle

   assign gate_ok = ~gate_en_i | gate_pin_i; // [RULE_11] [RULE_12]
   assign enable = run_i & gate_ok; // [RULE_03] [RULE_19]
   assign fall_seen = sample_reg & ~count_pin_i; // [RULE_07]
   // edge needs two samples, so at most one count per two ticks
   assign step = per_tick_i & enable &
      (src_sel_i ? fall_seen : 1'b1); // [RULE_06] [RULE_08]

   // ========================================================
   // next count value
   always @* begin
      low_next = low_o;
      high_next = high_o;
      ovf_next = 1'b0;
      if (step) begin
         case (mode_i)
            `MODE_13BIT: begin
               // upper three low bits are left alone [RULE_16]
               low_next[4:0] = low_o[4:0] + 5'h01; // [RULE_15]
               if (low_o[4:0] == `PRESCALE_TOP) begin
                  high_next = high_o + 8'h01; // [RULE_15]
                  ovf_next = (high_o == `BYTE_MAX); // [RULE_13]
               end
            end
            `MODE_16BIT: begin
               // low byte carries into high byte [RULE_02] [RULE_17]
               {high_next, low_next} = {high_o, low_o} + 16'h0001;
               ovf_next = (low_o == `BYTE_MAX) &&
                  (high_o == `BYTE_MAX); // [RULE_02] [RULE_13]
            end
            default: begin
               // other mode codes hold the count here [RULE_18]
               low_next = low_o;
            end
         endcase
      end
      // software preset wins; legal only while stopped
      if (wr_low_i) begin
         low_next = wdata_i;
      end
      if (wr_high_i) begin
         high_next = wdata_i;
      end
   end

   // ========================================================
   // count registers
   always @(posedge mclk_i) begin
      if (!rst_b_i) begin
         sample_reg <= 1'b0;
         low_o <= 8'h00;
         high_o <= 8'h00;
         ovf_o <= 1'b0;
      end else begin
         if (per_tick_i) begin
            sample_reg <= count_pin_i; // once per cycle [RULE_07]
         end
         low_o <= low_next;
         high_o <= high_next;
         ovf_o <= ovf_next;
      end
   end

endmodule

// *** hdl/timer_counter_modes_0_1.v ***
// two-counter timer block with AXI4-Lite registers and one interrupt
// assumes a single 250 MHz clock; pins arrive asynchronously
//
// Behaviour
// RULE_01: two independent counters, timer or event counter
// RULE_02: low byte carries into high; high overflow flags
// RULE_03: run bit enables counting, keeps count bytes
// RULE_04: software presets counts only while stopped
// RULE_05: software stops counter before mode/source change
// RULE_06: timer source counts once per six clocks
// RULE_07: count pin sampled per cycle, falls counted
// RULE_08: edge takes two cycles, twelve clocks minimum
// RULE_09: pin levels held one full peripheral cycle
// RULE_10: counter0 fields in low nibble, control bits
// RULE_11: gate clear runs on run bit alone
// RULE_12: gated counter counts only while pin high
// RULE_13: wrap to zero sets overflow flag, interrupt
// RULE_14: vectoring clears the overflow flag
// RULE_15: mode 0 is 5-bit prescaler plus 8-bit
// RULE_16: mode 0 ignores upper three low bits
// RULE_17: mode 1 is a full 16-bit cascade
// RULE_18: mode code 00 mode 0, 01 mode 1
// RULE_19: disabled counter holds its count bytes
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
`include "timer_counter_regs.vh"

module timer_counter_modes_0_1 #(
   parameter ADDR_W = 12
) (
   input wire mclk_i,
   input wire rst_b_i,
   input wire [ADDR_W-1:0] s_axi_awaddr_i,
   input wire s_axi_awvalid_i,
   output reg s_axi_awready_o,
   input wire [31:0] s_axi_wdata_i,
   input wire [3:0] s_axi_wstrb_i,
   input wire s_axi_wvalid_i,
   output reg s_axi_wready_o,
   output reg [1:0] s_axi_bresp_o,
   output reg s_axi_bvalid_o,
   input wire s_axi_bready_i,
   input wire [ADDR_W-1:0] s_axi_araddr_i,
   input wire s_axi_arvalid_i,
   output reg s_axi_arready_o,
   output reg [31:0] s_axi_rdata_o,
   output reg [1:0] s_axi_rresp_o,
   output reg s_axi_rvalid_o,
   input wire s_axi_rready_i,
   input wire [1:0] count_pin_i,
   input wire [1:0] gate_interrupt_pin_i,
   input wire [1:0] vector_ack_i,
   output reg irq_o
);

   // ========================================================
   // address decode helper
   // returns {hit, offset}; hit only inside the 32-byte window
   function [5:0] decode;
      input [ADDR_W-1:0] addr;
      begin
         decode = {(addr[ADDR_W-1:5] == {(ADDR_W-5){1'b0}}),
            addr[4:2], 2'h0};
      end
   endfunction

   // ========================================================
   // declarations
   reg [1:0] count_meta_reg; // first sync stage, count pins
   reg [1:0] count_sync_reg; // second sync stage
   reg [1:0] gate_meta_reg; // first sync stage, gate pins
   reg [1:0] gate_sync_reg; // second sync stage
   reg [1:0] gate_prev_reg; // for falling-edge interrupt detect
   reg [2:0] div_reg; // peripheral cycle divider
   reg per_tick_reg; // one pulse per peripheral cycle
   reg [7:0] ctrl_reg; // counter_control_register
   reg [7:0] ctrl_next;
   reg [7:0] mode_reg; // counter_mode_register
   reg [3:0] ist_reg; // sticky interrupt status
   reg [3:0] ist_next;
   reg [3:0] imask_reg; // interrupt mask
   reg aw_full_reg; // write address held
   reg w_full_reg; // write data held
   reg [ADDR_W-1:0] aw_addr_reg;
   reg [7:0] wdata_reg; // only the low byte is stored anywhere
   reg wstrb0_reg; // low byte lane enable
   reg [31:0] rdata_next;
   reg rhit_next;
   wire [5:0] wdec; // decoded write address
   wire [5:0] rdec; // decoded read address
   wire do_wr; // write performed this cycle
   wire wr_ok; // mapped write with low lane on
   wire [7:0] c0_low; // channel count bytes
   wire [7:0] c0_high;
   wire [7:0] c1_low;
   wire [7:0] c1_high;
   wire [1:0] ovf_evt; // one-cycle wrap pulses
   wire [1:0] ext_set; // external interrupt detection
   wire [1:0] ext_fall; // falling edge of gate pins
   wire [1:0] ext_type; // 1 edge, 0 level

   // ========================================================
   // pin synchronisers
   // first stage feeds only the second stage
   always @(posedge mclk_i) begin
      if (!rst_b_i) begin
         count_meta_reg <= 2'h0;
         count_sync_reg <= 2'h0;
         gate_meta_reg <= 2'h3; // idle high: no false level or edge
         gate_sync_reg <= 2'h3;
         gate_prev_reg <= 2'h3;
      end else begin
         count_meta_reg <= count_pin_i;
         count_sync_reg <= count_meta_reg;
         gate_meta_reg <= gate_interrupt_pin_i;
         gate_sync_reg <= gate_meta_reg;
         gate_prev_reg <= gate_sync_reg;
      end
   end

   // ========================================================
   // peripheral cycle divider: tick every six clocks
   always @(posedge mclk_i) begin
      if (!rst_b_i) begin
         div_reg <= 3'h0;
         per_tick_reg <= 1'b0;
      end else begin
         per_tick_reg <= (div_reg == `DIV_LAST); // [RULE_06]
         if (div_reg == `DIV_LAST) begin
            div_reg <= 3'h0;
         end else begin
            div_reg <= div_reg + 3'h1;
         end
      end
   end

   // ========================================================
   // write channel handshake
   // a write finishes only after both halves are held
   assign do_wr = aw_full_reg & w_full_reg & ~s_axi_bvalid_o;
   assign wdec = decode(aw_addr_reg);
   assign wr_ok = do_wr & wdec[5] & wstrb0_reg;

   always @(posedge mclk_i) begin
      if (!rst_b_i) begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         aw_addr_reg <= {ADDR_W{1'b0}};
         wdata_reg <= 8'h00;
         wstrb0_reg <= 1'b0;
         s_axi_awready_o <= 1'b1;
         s_axi_wready_o <= 1'b1;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= `RESP_OKAY;
      end else begin
         // address taken, hold until response accepted
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr_i;
            s_axi_awready_o <= 1'b0;
         end
         // data taken independently of the address
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_full_reg <= 1'b1;
            wdata_reg <= s_axi_wdata_i[7:0];
            wstrb0_reg <= s_axi_wstrb_i[0];
            s_axi_wready_o <= 1'b0;
         end
         if (do_wr) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            // unmapped addresses answer with a slave error
            s_axi_bresp_o <= wdec[5] ? `RESP_OKAY : `RESP_SLVERR;
         end
         // reopen both channels when the response leaves
         if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o <= 1'b1;
         end
      end
   end

   // ========================================================
   // external interrupt flags and control register
   assign ext_type = {ctrl_reg[`CTL_TYPE1], ctrl_reg[`CTL_TYPE0]};
   assign ext_fall = gate_prev_reg & ~gate_sync_reg;
   // edge type catches falls, level type catches a low pin
   assign ext_set = (ext_type & ext_fall) | (~ext_type & ~gate_sync_reg);

   // hardware sets win over software clears and vector acks
   always @* begin
      ctrl_next = ctrl_reg;
      if (vector_ack_i[0]) begin
         ctrl_next[`CTL_OVF0] = 1'b0; // [RULE_14]
      end
      if (vector_ack_i[1]) begin
         ctrl_next[`CTL_OVF1] = 1'b0; // [RULE_14]
      end
      if (wr_ok && wdec[4:0] == `OFS_CTRL) begin
         ctrl_next = wdata_reg;
      end
      if (ovf_evt[0]) begin
         ctrl_next[`CTL_OVF0] = 1'b1; // [RULE_13] [RULE_02]
      end
      if (ovf_evt[1]) begin
         ctrl_next[`CTL_OVF1] = 1'b1; // [RULE_13] [RULE_02]
      end
      if (ext_set[0]) begin
         ctrl_next[`CTL_EXTF0] = 1'b1;
      end
      if (ext_set[1]) begin
         ctrl_next[`CTL_EXTF1] = 1'b1;
      end
   end

   // ========================================================
   // interrupt status: write one to clear, events win
   always @* begin
      ist_next = ist_reg;
      if (wr_ok && wdec[4:0] == `OFS_IRQ_STAT) begin
         ist_next = ist_reg & ~wdata_reg[3:0];
      end
      if (ovf_evt[0]) begin
         ist_next[`IST_OVF0] = 1'b1;
      end
      if (ovf_evt[1]) begin
         ist_next[`IST_OVF1] = 1'b1;
      end
      // only a new assertion of the flag counts as an event
      if (ext_set[0] && !ctrl_reg[`CTL_EXTF0]) begin
         ist_next[`IST_EXT0] = 1'b1;
      end
      if (ext_set[1] && !ctrl_reg[`CTL_EXTF1]) begin
         ist_next[`IST_EXT1] = 1'b1;
      end
   end

   // ========================================================
   // control, mode, status and mask registers
   always @(posedge mclk_i) begin
      if (!rst_b_i) begin
         ctrl_reg <= 8'h00;
         mode_reg <= 8'h00;
         ist_reg <= 4'h0;
         imask_reg <= 4'h0;
         irq_o <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         ist_reg <= ist_next;
         // mode is taken as written; stopping first is software's job
         if (wr_ok && wdec[4:0] == `OFS_MODE) begin
            mode_reg <= wdata_reg; // [RULE_05]
         end
         if (wr_ok && wdec[4:0] == `OFS_IRQ_MASK) begin
            imask_reg <= wdata_reg[3:0];
         end
         // built from the next status, so it moves with the status bit
         irq_o <= |(ist_next & imask_reg);
      end
   end

   // ========================================================
   // the two counter channels [RULE_01]
   // counter0 uses the low mode nibble and its control bits [RULE_10]
   counter_channel u_counter0 (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .per_tick_i(per_tick_reg),
      .run_i(ctrl_reg[`CTL_RUN0]),
      .gate_en_i(mode_reg[`MD_GATE]),
      .src_sel_i(mode_reg[`MD_SRC]),
      .mode_i({mode_reg[`MD_SEL_HI], mode_reg[`MD_SEL_LO]}),
      .gate_pin_i(gate_sync_reg[0]),
      .count_pin_i(count_sync_reg[0]),
      .wr_low_i(wr_ok && wdec[4:0] == `OFS_C0_LOW), // [RULE_04]
      .wr_high_i(wr_ok && wdec[4:0] == `OFS_C0_HIGH),
      .wdata_i(wdata_reg),
      .low_o(c0_low),
      .high_o(c0_high),
      .ovf_o(ovf_evt[0])
   );

   // counter1 uses the high nibble and the other control bits
   counter_channel u_counter1 (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .per_tick_i(per_tick_reg),
      .run_i(ctrl_reg[`CTL_RUN1]),
      .gate_en_i(mode_reg[`MD_C1_LSB+`MD_GATE]),
      .src_sel_i(mode_reg[`MD_C1_LSB+`MD_SRC]),
      .mode_i({mode_reg[`MD_C1_LSB+`MD_SEL_HI],
         mode_reg[`MD_C1_LSB+`MD_SEL_LO]}),
      .gate_pin_i(gate_sync_reg[1]),
      .count_pin_i(count_sync_reg[1]),
      .wr_low_i(wr_ok && wdec[4:0] == `OFS_C1_LOW),
      .wr_high_i(wr_ok && wdec[4:0] == `OFS_C1_HIGH),
      .wdata_i(wdata_reg),
      .low_o(c1_low),
      .high_o(c1_high),
      .ovf_o(ovf_evt[1])
   );

   // ========================================================
   // read data selection; counts readable at any time [RULE_04]
   assign rdec = decode(s_axi_araddr_i);

   always @* begin
      rdata_next = 32'h00000000;
      rhit_next = rdec[5];
      case (rdec[4:0])
         `OFS_CTRL: rdata_next[7:0] = ctrl_reg;
         `OFS_MODE: rdata_next[7:0] = mode_reg;
         `OFS_C0_LOW: rdata_next[7:0] = c0_low;
         `OFS_C0_HIGH: rdata_next[7:0] = c0_high;
         `OFS_C1_LOW: rdata_next[7:0] = c1_low;
         `OFS_C1_HIGH: rdata_next[7:0] = c1_high;
         `OFS_IRQ_STAT: rdata_next[3:0] = ist_reg;
         `OFS_IRQ_MASK: rdata_next[3:0] = imask_reg;
         default: rhit_next = 1'b0;
      endcase
      if (!rhit_next) begin
         rdata_next = 32'h00000000;
      end
   end

   // ========================================================
   // read channel: one read in flight, data from a register
   always @(posedge mclk_i) begin
      if (!rst_b_i) begin
         s_axi_arready_o <= 1'b1;
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= 32'h00000000;
         s_axi_rresp_o <= `RESP_OKAY;
      end else begin
         if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= rdata_next;
            s_axi_rresp_o <= rhit_next ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_arready_o <= 1'b1;
         end
      end
   end

endmodule

// *** test/timer_chk.sv ***
// checker: bus handshake and interrupt timing of the timer block
// assumes a bind onto timer_counter_modes_0_1 and one clock domain
`timescale 1ns/100ps
module timer_chk (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic s_axi_awvalid_i,
   input wire logic s_axi_awready_o,
   input wire logic s_axi_wvalid_i,
   input wire logic s_axi_wready_o,
   input wire logic [1:0] s_axi_bresp_o,
   input wire logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic s_axi_arvalid_i,
   input wire logic s_axi_arready_o,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic irq_o
);
   // ========================================================
   // handshake steps shared by the properties
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   sequence wr_take;
      s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
   endsequence
   sequence rd_take;
      s_axi_arvalid_i && s_axi_arready_o;
   endsequence
   sequence b_take;
      s_axi_bvalid_o && s_axi_bready_i;
   endsequence
   sequence r_take;
      s_axi_rvalid_o && s_axi_rready_i;
   endsequence
   // ========================================================
   // register bus answers
   wr_ans_a: assert property (wr_take |-> ##2 s_axi_bvalid_o)
      else $error("write answer missing");
   b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i
      |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
      else $error("write answer dropped");
   rd_ans_a: assert property (rd_take |=> s_axi_rvalid_o)
      else $error("read answer missing");
   r_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i
      |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
      else $error("read data moved");
   w_busy_a: assert property (s_axi_bvalid_o
      |-> !s_axi_awready_o && !s_axi_wready_o)
      else $error("write accepted while busy");
   r_busy_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
      else $error("read accepted while busy");
   b_done_a: assert property (b_take
      |=> !s_axi_bvalid_o && s_axi_awready_o && s_axi_wready_o)
      else $error("write not closed");
   r_done_a: assert property (r_take
      |=> !s_axi_rvalid_o && s_axi_arready_o)
      else $error("read not closed");
   // interrupt drops only after a register write (clear or mask)
   irq_drop_a: assert property ($fell(irq_o)
      |-> s_axi_bvalid_o || $past(s_axi_bvalid_o))
      else $error("interrupt dropped without a write");
endmodule

// *** test/pin_model.sv ***
// far side: external count pins and gate pins, driven as levels
// assumes the bench calls its tasks; pins idle high between bursts
`timescale 1ns/100ps
module pin_model (
   input wire logic mclk_i,
   output logic [1:0] count_pin_o,
   output logic [1:0] gate_pin_o
);
   // ========================================================
   // idle levels: high, so no edge and no gate block at start
   initial begin
      count_pin_o = 2'h3;
      gate_pin_o = 2'h3;
   end
   // n falling edges on pin 1, each level held one peripheral cycle
   // (six clocks), the fastest rate the counter must follow
   task burst(input int n);
      repeat (n) begin
         repeat (6) @(posedge mclk_i);
         count_pin_o[1] <= 1'b0;
         repeat (6) @(posedge mclk_i);
         count_pin_o[1] <= 1'b1;
      end
   endtask
   // gate level for counter 0
   task set_gate(input logic v);
      @(posedge mclk_i);
      gate_pin_o[0] <= v;
   endtask
endmodule

// *** test/testbench.sv ***
// bench: register table, timer, gate, mode 0 and pin counting
// assumes the checker and pin model files are compiled before it
`timescale 1ns/100ps
module testbench;
   // ========================================================
   // stimulus and observed signals
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic [11:0] awaddr = 12'h000;
   logic [11:0] araddr = 12'h000;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [1:0] vack = 2'h0;
   wire awready, wready, bvalid, arready, rvalid, irq;
   wire [1:0] bresp, rresp, cpin, gpin;
   wire [31:0] rdata;
   logic [31:0] rdat;
   logic [1:0] resp;
   int errors = 0, checks = 0, cyc = 0, n;
   typedef struct {logic [11:0] a; logic [31:0] d, q; logic [1:0] r;} row_t;
   // plain register cases: address, write, readback, response
   row_t rows [8] = '{'{12'h004, 32'h5A, 32'h5A, 2'h0},
      '{12'h008, 32'h1A5, 32'hA5, 2'h0}, '{12'h00C, 32'h3C, 32'h3C, 2'h0},
      '{12'h010, 32'hC3, 32'hC3, 2'h0}, '{12'h014, 32'h7E, 32'h7E, 2'h0},
      '{12'h01C, 32'hFF, 32'h0F, 2'h0}, '{12'h000, 32'h05, 32'h05, 2'h0},
      '{12'h020, 32'h11, 32'h00, 2'h2}};
   always #2 mclk = ~mclk;
   timer_counter_modes_0_1 #(.ADDR_W(12)) dut_u (.mclk_i(mclk),
      .rst_b_i(rst_b), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
      .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .count_pin_i(cpin),
      .gate_interrupt_pin_i(gpin), .vector_ack_i(vack), .irq_o(irq));
   pin_model pins_u (.mclk_i(mclk), .count_pin_o(cpin), .gate_pin_o(gpin));
   // ========================================================
   // compare, bus tasks and closing report
   task chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task inside_rng(input int v, input int lo, input int hi);
      chk({31'h0, (v >= lo && v <= hi)}, 32'h1);
   endtask
   // write: both channels offered together, each dropped when taken;
   // handshakes judged at the falling edge to avoid edge races
   task wr(input logic [11:0] a, input logic [31:0] d);
      logic ha, hw, hb;
      @(posedge mclk);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
      bready <= 1'b1;
      hb = 1'b0;
      while (!hb) begin
         @(negedge mclk);
         ha = awvalid && awready; hw = wvalid && wready; hb = bvalid;
         resp = bresp;
         @(posedge mclk);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
         if (hb) bready <= 1'b0;
      end
   endtask
   task rd(input logic [11:0] a);
      logic ha, hr;
      @(posedge mclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      hr = 1'b0;
      while (!hr) begin
         @(negedge mclk);
         ha = arvalid && arready; hr = rvalid; rdat = rdata; resp = rresp;
         @(posedge mclk);
         if (ha) arvalid <= 1'b0;
         if (hr) rready <= 1'b0;
      end
   endtask
   task results;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // hang guard: whole run needs a few hundred cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         results;
      end
   end
   // ========================================================
   // main sequence
   initial begin
      repeat (20) @(posedge mclk);
      rst_b <= 1'b1;
      for (int i = 0; i < 32; i += 4) begin
         rd(i[11:0]);
         chk(rdat, 32'h0);
      end
      $display("reset values done");
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         chk({30'h0, resp}, {30'h0, rows[i].r});
         rd(rows[i].a);
         chk(rdat, rows[i].q);
         chk({30'h0, resp}, {30'h0, rows[i].r});
      end
      $display("register rows done");
      // counter 0, mode 1, preset near the top, run until overflow
      wr(12'h000, 32'h0); wr(12'h004, 32'h01); wr(12'h008, 32'hFD);
      wr(12'h00C, 32'hFF); wr(12'h01C, 32'h01); wr(12'h000, 32'h10);
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (irq !== 1'b1 && n < 100);
      inside_rng(n, 12, 30);
      rd(12'h000);
      chk(rdat, 32'h30);
      rd(12'h018);
      chk(rdat, 32'h01);
      rd(12'h00C);
      chk(rdat, 32'h00);
      @(posedge mclk) vack <= 2'h1;
      @(posedge mclk) vack <= 2'h0;
      rd(12'h000);
      chk(rdat, 32'h10);
      wr(12'h018, 32'h01);
      repeat (2) @(negedge mclk);
      chk({31'h0, irq}, 32'h0);
      $display("overflow test done");
      // mode 0: prescaler carry, upper low-byte bits left alone
      wr(12'h000, 32'h0); wr(12'h004, 32'h00); wr(12'h008, 32'hFE);
      wr(12'h00C, 32'h00); wr(12'h000, 32'h10);
      repeat (30) @(posedge mclk);
      wr(12'h000, 32'h0);
      rd(12'h00C);
      chk(rdat, 32'h01);
      rd(12'h008);
      chk({29'h0, rdat[7:5]}, 32'h7);
      $display("mode 0 test done");
      // mode code 10 belongs elsewhere: the high count byte must hold
      wr(12'h004, 32'h02); wr(12'h000, 32'h10);
      repeat (30) @(posedge mclk);
      wr(12'h000, 32'h0);
      rd(12'h00C);
      chk(rdat, 32'h01);
      $display("mode 2 hold test done");
      // gated timer: blocked while gate pin low, counts while high
      wr(12'h008, 32'h0); wr(12'h00C, 32'h0); wr(12'h004, 32'h09);
      pins_u.set_gate(1'b0);
      wr(12'h000, 32'h10);
      repeat (60) @(posedge mclk);
      rd(12'h008);
      chk(rdat, 32'h0);
      pins_u.set_gate(1'b1);
      repeat (60) @(posedge mclk);
      wr(12'h000, 32'h0);
      rd(12'h008);
      inside_rng(int'(rdat), 9, 12);
      $display("gate test done");
      // counter 1 on its pin: five falls at the highest rate
      wr(12'h010, 32'h0); wr(12'h014, 32'h0); wr(12'h004, 32'h50);
      wr(12'h000, 32'h40);
      pins_u.burst(5);
      repeat (12) @(posedge mclk);
      rd(12'h010);
      chk(rdat, 32'h05);
      wr(12'h000, 32'h0);
      $display("pin count test done");
      results;
   end
endmodule
bind timer_counter_modes_0_1 timer_chk chk_u (.mclk_i(mclk_i),
   .rst_b_i(rst_b_i), .s_axi_awvalid_i(s_axi_awvalid_i),
   .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
   .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
   .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
   .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
   .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rvalid_o(s_axi_rvalid_o),
   .s_axi_rready_i(s_axi_rready_i), .irq_o(irq_o));
